// file: pb_endian_pkg.sv
package pb_endian_pkg;
  // Endian select values
  localparam logic END_BIG = 1'b0;
  localparam logic END_MUNGED_LE = 1'b1;
  localparam logic END_RESET = END_BIG;
  // Transfer size codes, in bytes
  localparam logic [2:0] SIZE_BYTE = 3'h1;
  localparam logic [2:0] SIZE_TWO = 3'h2;
  localparam logic [2:0] SIZE_TRI = 3'h3;
  localparam logic [2:0] SIZE_WORD = 3'h4;
  // Low address field position within the processor address
  localparam int ADDR_LOW_FIRST = 29;
  // Width of one byte lane
  localparam int LANE_BITS = 8;
  localparam int LANES = 8;
  // Slave states
  typedef enum logic [1:0] {ST_IDLE, ST_WAIT, ST_DONE} slave_state_e;
endpackage

// file: pci_lane_steer.sv
`timescale 1ns/1ps
module pci_lane_steer (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic resetn,
  // Little-endian byte image, byte k at bits 8k+7:8k
  input wire logic load,
  input wire logic [63:0] byteImage,
  input wire logic dwordSel,
  // PCI to PCI forwarding
  input wire logic [63:0] fwdIn,
  output logic [63:0] fwdOut,
  // PCI lanes
  output logic [63:0] pciFirstAddrData,
  output logic [31:0] pciAnyAddrData
);
  // Double-word picked by dwordSel, the upper half when set
  wire [31:0] dwordPick = dwordSel ? byteImage[63:32] : byteImage[31:0];

  // Lane registers
  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      pciFirstAddrData <= 64'h0;
      pciAnyAddrData <= 32'h0;
      fwdOut <= 64'h0;
    end
    else
    begin
      fwdOut <= fwdIn;
      if (load)
      begin
        pciFirstAddrData <= byteImage;
        pciAnyAddrData <= dwordPick;
      end
    end
  end
endmodule

// file: pb_register_endian_mapper.sv
`timescale 1ns/1ps
module pb_register_endian_mapper (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic resetn,
  // Endian select control
  input wire logic endWrite,
  input wire logic endValue,
  output logic endSelect,
  // Processor bus request
  input wire logic procReq,
  input wire logic procWrite,
  input wire logic [2:0] procXferSize,
  input wire logic [0:31] proc_bus_addr,
  input wire logic [0:63] proc_bus_data,
  // Processor bus answer
  output logic procAck,
  output logic proc_transfer_error_ack,
  output logic [0:63] procRdata,
  // Register file side
  output logic regReq,
  output logic regWrite,
  output logic [28:0] regAddr,
  output logic [7:0] regByteEn,
  output logic [63:0] regWdata,
  input wire logic regAck,
  input wire logic [63:0] regRdata,
  // PCI forwarding and lanes
  input wire logic [63:0] pciFwdIn,
  output logic [63:0] pciFwdOut,
  output logic [63:0] pci_first_addr_data,
  output logic [31:0] pci_any_addr_data
);
  // Register byte index for processor lane n
  function automatic logic [2:0] lane_to_reg(input logic [2:0] n, input logic le,
                                             input logic [1:0] m);
    if (le)
      lane_to_reg = {~n[2], n[1:0] ^ m};
    else
      lane_to_reg = {n[2], 2'h3 - n[1:0]};
  endfunction

  // Whether a lane falls inside the bytes of a transfer
  function automatic logic lane_in_span(input logic [2:0] n, input logic [2:0] start,
                                        input logic [2:0] size);
    logic [3:0] rel;
    rel = {1'b0, n} - {1'b0, start};
    lane_in_span = (n >= start) && (rel < {1'b0, size});
  endfunction

  pb_endian_pkg::slave_state_e state;
  logic le;
  logic [1:0] sigXor;
  logic [2:0] startAddr;
  logic [2:0] sizeHeld;
  pb_endian_pkg::slave_state_e next_state;

  // Decode of the request as presented
  wire [2:0] reqStart = proc_bus_addr[pb_endian_pkg::ADDR_LOW_FIRST +: 3];
  wire [3:0] reqEnd = {1'b0, reqStart} + {1'b0, procXferSize};
  wire fitsDword = reqEnd <= {1'b0, reqStart[2], 2'h0} + 4'h4;
  // Size code decode
  wire isByte = procXferSize == pb_endian_pkg::SIZE_BYTE;
  wire isTwo = procXferSize == pb_endian_pkg::SIZE_TWO;
  wire isTri = procXferSize == pb_endian_pkg::SIZE_TRI;
  wire isWord = procXferSize == pb_endian_pkg::SIZE_WORD;
  // Supported size and start pairs per byte order
  wire beLegal = fitsDword && (isByte || isTwo || (isTri && !reqStart[1])
    || (isWord && reqStart[1:0] == 2'h0));
  wire leLegal = isByte || (isTwo && !reqStart[0])
    || (isWord && reqStart[1:0] == 2'h0);
  wire reqLegal = (endSelect == pb_endian_pkg::END_MUNGED_LE) ? leLegal : beLegal;
  // Significance twist per size for munged order
  wire [1:0] reqXor = isWord ? 2'h3 : isTwo ? 2'h1 : 2'h0;

  // Per-lane steering, both directions
  logic [7:0] nextByteEn;
  logic [63:0] nextWdata;
  logic [0:63] nextRdata;
  genvar g;
  generate
    for (g = 0; g < pb_endian_pkg::LANES; g++)
    begin : gLane
      wire [2:0] lane = 3'(g);
      wire [2:0] reqLane = lane_to_reg(lane, endSelect, reqXor);
      wire reqActive = lane_in_span(reqLane, reqStart, procXferSize);
      wire [2:0] holdIdx = lane_to_reg(lane, le, sigXor);
      wire holdActive = lane_in_span(lane, startAddr, sizeHeld);
      // Write side: register byte g fed from the lane that maps onto it
      assign nextByteEn[g] = reqActive;
      assign nextWdata[g*8 +: 8] = reqActive ? proc_bus_data[reqLane*8 +: 8] : 8'h0;
      // Read side: register byte back to processor lane
      assign nextRdata[g*8 +: 8] = holdActive ? regRdata[holdIdx*8 +: 8] : 8'h0;
    end
  endgenerate

  // Request take and completion events
  wire inIdle = state == pb_endian_pkg::ST_IDLE;
  wire takeError = inIdle && procReq && !reqLegal;
  wire takeAccess = inIdle && procReq && reqLegal;
  wire regDone = state == pb_endian_pkg::ST_WAIT && regAck;
  wire selectLoad = endWrite && inIdle && !procReq;
  // PCI double-word follows the upper register byte enables, which match address bit 2 only in big-endian order
  wire upperDword = regByteEn[7:4] != 4'h0;

  // Endian select bit
  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
      endSelect <= pb_endian_pkg::END_RESET;
    else if (selectLoad)
      endSelect <= endValue;
  end

  // State successor
  always_comb
  begin
    next_state = state;
    case (state)
      pb_endian_pkg::ST_IDLE:
      begin
        if (takeError)
          next_state = pb_endian_pkg::ST_DONE;
        else if (takeAccess)
          next_state = pb_endian_pkg::ST_WAIT;
      end
      pb_endian_pkg::ST_WAIT:
      begin
        if (regAck)
          next_state = pb_endian_pkg::ST_DONE;
      end
      pb_endian_pkg::ST_DONE:
        next_state = pb_endian_pkg::ST_IDLE;
      default:
        next_state = pb_endian_pkg::ST_IDLE;
    endcase
  end

  // State register
  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
      state <= pb_endian_pkg::ST_IDLE;
    else
      state <= next_state;
  end

  // One-cycle strobes towards both sides
  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      procAck <= 1'b0;
      proc_transfer_error_ack <= 1'b0;
      regReq <= 1'b0;
    end
    else
    begin
      procAck <= regDone;
      proc_transfer_error_ack <= takeError;
      regReq <= takeAccess;
    end
  end

  // Request image towards the register file, held until the next take
  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      regWrite <= 1'b0;
      regAddr <= 29'h0;
      regByteEn <= 8'h0;
      regWdata <= 64'h0;
    end
    else if (takeAccess)
    begin
      regWrite <= procWrite;
      regAddr <= proc_bus_addr[0:28];
      regByteEn <= nextByteEn;
      regWdata <= nextWdata;
    end
  end

  // Order, twist and span kept for steering the read data back
  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      le <= pb_endian_pkg::END_RESET;
      sigXor <= 2'h0;
      startAddr <= 3'h0;
      sizeHeld <= 3'h0;
    end
    else if (takeAccess)
    begin
      le <= endSelect;
      sigXor <= reqXor;
      startAddr <= reqStart;
      sizeHeld <= procXferSize;
    end
  end

  // Read data returned with the acknowledge, zero on writes
  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
      procRdata <= 64'h0;
    else if (regDone)
      procRdata <= regWrite ? 64'h0 : nextRdata;
  end

  // PCI lane view of the converted write image, plus PCI forwarding
  pci_lane_steer laneSteer (
    .ref_clk(ref_clk),
    .resetn(resetn),
    .load(regReq),
    .byteImage(regWdata),
    .dwordSel(upperDword),
    .fwdIn(pciFwdIn),
    .fwdOut(pciFwdOut),
    .pciFirstAddrData(pci_first_addr_data),
    .pciAnyAddrData(pci_any_addr_data)
  );
endmodule

// file: pb_register_endian_mapper_props.sv
`timescale 1ns/1ps
module pb_register_endian_mapper_props (
  // Clock, reset, select
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic endWrite,
  input wire logic endValue,
  input wire logic endSelect,
  // Processor side
  input wire logic procReq,
  input wire logic [2:0] procXferSize,
  input wire logic [0:31] proc_bus_addr,
  input wire logic procAck,
  input wire logic proc_transfer_error_ack,
  // Register and PCI side
  input wire logic regReq,
  input wire logic [7:0] regByteEn,
  input wire logic [63:0] regWdata,
  input wire logic regAck,
  input wire logic [63:0] pciFwdIn,
  input wire logic [63:0] pciFwdOut,
  input wire logic [63:0] pci_first_addr_data
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!resetn);
  // Aligned word requests per mode
  wire wordAt0 = procReq && procXferSize == 3'h4 && proc_bus_addr[29:31] == 3'h0;
  be_word_a: assert property (wordAt0 && !endSelect |=> regReq && regByteEn == 8'h0f)
    else $error("be word lanes");
  le_word_a: assert property (wordAt0 && endSelect |=> regReq && regByteEn == 8'hf0)
    else $error("le word lanes");
  le_unaligned_a: assert property (procReq && endSelect && procXferSize != 3'h1
    && proc_bus_addr[31] |=> proc_transfer_error_ack)
    else $error("le unaligned taken");
  err_no_write_a: assert property (proc_transfer_error_ack |-> !regReq && !procAck)
    else $error("error with access");
  fwd_plain_a: assert property ($past(resetn) |-> pciFwdOut == $past(pciFwdIn))
    else $error("fwd altered");
  pci_lanes_a: assert property (regReq |=> pci_first_addr_data == $past(regWdata))
    else $error("pci lanes");
  ack_follows_a: assert property (regReq ##1 regAck |=> procAck)
    else $error("no ack");
  end_load_a: assert property (endWrite && !procReq |=> endSelect == $past(endValue))
    else $error("select not loaded");
  // Main scenarios
  cover property (procAck);
  cover property (proc_transfer_error_ack && endSelect);
  cover property (regReq && endSelect);
endmodule
bind pb_register_endian_mapper pb_register_endian_mapper_props pb_register_endian_mapper_props_i (.*);

// file: reg_file_model.sv
`timescale 1ns/1ps
module reg_file_model (
  // Clock
  input wire logic ref_clk,
  // Request from the slave
  input wire logic regReq,
  input wire logic regWrite,
  input wire logic [7:0] regByteEn,
  input wire logic [63:0] regWdata,
  // Answer late when set
  input wire logic slow,
  // Answer to the slave
  output logic regAck = 1'b0,
  output logic [63:0] regRdata = 64'h0
);
  logic [63:0] mem = 64'h0;
  logic [2:0] cnt = 3'h0;
  // One ack per request; idle data toggles
  always @(posedge ref_clk)
  begin
    regAck <= regReq ? !slow : (cnt == 3'h1);
    regRdata <= (regReq || cnt == 3'h1) ? mem : ~regRdata;
    cnt <= regReq ? (slow ? 3'h4 : 3'h0) : cnt - {2'h0, cnt != 3'h0};
    for (int k = 0; k < 8; k++)
      if (regReq && regWrite && regByteEn[k])
        mem[8*k +: 8] <= regWdata[8*k +: 8];
  end
endmodule

// file: pb_register_endian_mapper_bench.sv
`timescale 1ns/1ps
module pb_register_endian_mapper_bench;
  logic ref_clk = 1'b0, resetn = 1'b0, endWrite = 1'b0, endValue = 1'b0;
  logic procReq = 1'b0, procWrite = 1'b0, slow = 1'b0;
  logic [2:0] procXferSize = 3'h1;
  logic [0:31] proc_bus_addr = 32'h0;
  logic [0:63] proc_bus_data = 64'h0;
  logic [63:0] pciFwdIn = 64'h0;
  logic endSelect, procAck, proc_transfer_error_ack, regReq, regWrite, regAck;
  logic [0:63] procRdata;
  logic [28:0] regAddr;
  logic [7:0] regByteEn;
  logic [63:0] regWdata, regRdata, pciFwdOut, pci_first_addr_data;
  logic [31:0] pci_any_addr_data;
  logic [1:0] res;
  int err_total = 0, compares = 0;
  pb_register_endian_mapper pb_register_endian_mapper_i (.*);
  reg_file_model reg_file_model_i (.*);
  task automatic chk(input string nm, input logic [63:0] got, exp);
    compares++;
    if (got !== exp)
    begin
      err_total++;
      $display("FAIL %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task report_and_stop;
    if (err_total == 0 && compares > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  // One processor access; res is {error, ack}
  task automatic acc(input logic w, input logic [2:0] sz, input logic [0:31] a,
                     input logic [0:63] d);
    int n;
    n = 0;
    @(posedge ref_clk);
    #1;
    {procReq, procWrite, procXferSize, proc_bus_addr, proc_bus_data} = {1'b1, w, sz, a, d};
    @(posedge ref_clk);
    #1;
    procReq = 1'b0;
    while (!(procAck || proc_transfer_error_ack) && n < 20)
    begin
      @(posedge ref_clk);
      #1;
      n++;
    end
    res = {proc_transfer_error_ack, procAck};
    @(posedge ref_clk);
  endtask
  task automatic set_end(input logic v);
    @(posedge ref_clk);
    #1;
    endWrite = 1'b1;
    endValue = v;
    @(posedge ref_clk);
    #1;
    endWrite = 1'b0;
    chk("endSelect", endSelect, v);
  endtask
  task automatic t_be;
    chk("select reset", endSelect, 1'b0);
    acc(1'b1, 3'h4, 32'h0, 64'h11223344_55667788);
    chk("word res", res, 2'b01);
    chk("word lanes", {regByteEn, regWdata[31:0]}, 40'h0f_11223344);
    chk("pci dword", pci_any_addr_data, 32'h11223344);
    chk("pci qword", pci_first_addr_data, 64'h00000000_11223344);
    chk("word write", regWrite, 1'b1);
    chk("write rdata", procRdata, 64'h0);
    acc(1'b1, 3'h2, 32'h3, 64'h0);
    chk("odd res", res, 2'b10);
    slow = 1'b1;
    acc(1'b0, 3'h3, 32'h9, 64'h0);
    slow = 1'b0;
    chk("tri read", procRdata, 64'h00223344_00000000);
    chk("tri addr", {regWrite, regAddr}, 30'h1);
  endtask
  task automatic t_le;
    set_end(1'b1);
    acc(1'b1, 3'h4, 32'h0, 64'hdeadbeef_00000000);
    chk("le word lanes", {regByteEn, regWdata[63:32]}, 40'hf0_deadbeef);
    chk("pci upper dword", pci_any_addr_data, 32'hdeadbeef);
    acc(1'b1, 3'h2, 32'h6, 64'h0000_0000_0000_a1b2);
    chk("le half lanes", {regByteEn, regWdata[31:16]}, 24'h0c_a1b2);
    acc(1'b0, 3'h4, 32'h4, 64'h0);
    chk("le word read", procRdata, 64'h00000000_a1b23344);
    acc(1'b0, 3'h2, 32'h1, 64'h0);
    chk("le odd res", res, 2'b10);
    acc(1'b0, 3'h3, 32'h0, 64'h0);
    chk("le tri res", res, 2'b10);
    set_end(1'b0);
  endtask
  task automatic t_fwd;
    @(posedge ref_clk);
    #1;
    pciFwdIn = 64'h0123456789abcdef;
    @(posedge ref_clk);
    #1;
    chk("fwd", pciFwdOut, 64'h0123456789abcdef);
  endtask
  initial
  begin
    repeat (4) @(posedge ref_clk);
    #1;
    resetn = 1'b1;
    t_be;
    t_le;
    t_fwd;
    report_and_stop;
  end
  initial
    forever #2 ref_clk = ~ref_clk;
  initial
  begin
    #10000;
    err_total++;
    report_and_stop;
  end
endmodule
